/* File: ncal_alu.sv */
`timescale 1ns/1ps
`include "ncal_map.svh"
module ncal_alu (
  input wire logic core_clk_i, // core clock
  input wire logic resetn_i, // synchronous reset, active low
  input wire logic op_valid_i, // one-cycle instruction strobe
  input wire ncal_pkg::ncal_req_type op_i, // instruction and operands
  output logic done_o, // one-cycle result strobe
  output ncal_pkg::ncal_res_type res_o, // write-back target and data
  output logic skip_req_o, // skip next instruction
  output logic illegal_o, // destination or opcode not allowed, nothing written
  output logic carry_flag_o // carry flag
);
  import ncal_pkg::*;

  logic [7:0] wide;
  logic [3:0] n_a;
  logic [3:0] n_b;
  logic n_cin;
  logic n_sub;
  logic [3:0] n_sum;
  logic n_co;
  logic [7:0] b_a;
  logic [7:0] b_b;
  logic b_cin;
  logic b_sub;
  logic [7:0] b_sum;
  logic b_co;
  ncal_res_type res_next;
  logic skip_next;
  logic carry_we;
  logic carry_next;
  logic bad_next;
  logic discard;
  logic fire;
  logic conv_op;
  logic conv_skip_next;
  logic carry_flag_reg;
  logic skip_shadow_reg;
  logic conv_pending_reg;
  logic conv_skip_reg;
  logic done_reg;
  ncal_res_type res_reg;
  logic skip_req_reg;
  logic illegal_reg;

  assign wide = {op_i.high, op_i.acc};

  ncal_addsub #(
    .W(`NCAL_NIB_W)
  ) u_nib (
    .a_i(n_a),
    .b_i(n_b),
    .cin_i(n_cin),
    .sub_i(n_sub),
    .sum_o(n_sum),
    .cout_o(n_co)
  );

  ncal_addsub #(
    .W(`NCAL_BYTE_W)
  ) u_byte (
    .a_i(b_a),
    .b_i(b_b),
    .cin_i(b_cin),
    .sub_i(b_sub),
    .sum_o(b_sum),
    .cout_o(b_co)
  );

  // an instruction behind a skip request is swallowed whole
  assign discard = skip_shadow_reg;
  assign fire = op_valid_i && !discard;

  // operand steering and result forming; carry is held unless written
  always_comb begin
    n_a = op_i.acc;
    n_b = op_i.mem;
    n_cin = 1'b0;
    n_sub = 1'b0;
    b_a = wide;
    b_b = op_i.pair;
    b_cin = 1'b0;
    b_sub = 1'b0;
    res_next.dst = NCAL_DST_NONE;
    res_next.sel = op_i.sel;
    res_next.data = `NCAL_BYTE_ZERO;
    res_next.addr = op_i.pointer;
    skip_next = 1'b0;
    carry_we = 1'b0;
    carry_next = carry_flag_reg;
    bad_next = 1'b0;
    conv_op = 1'b0;
    conv_skip_next = 1'b0;
    unique case (op_i.code)
      NCAL_OP_NOP: begin
        res_next.dst = NCAL_DST_NONE;
      end
      NCAL_OP_ADDS_ACC_IMM: begin
        n_b = op_i.imm[3:0];
        res_next.dst = NCAL_DST_ACC;
        res_next.data = {4'h0, n_sum};
        skip_next = n_co;
        if (conv_pending_reg && conv_skip_reg) begin
          res_next.dst = NCAL_DST_NONE;
          skip_next = 1'b0;
        end else if (conv_pending_reg) begin
          skip_next = 1'b0;
        end
      end
      NCAL_OP_ADDS_WIDE_IMM: begin
        b_b = op_i.imm;
        res_next.dst = NCAL_DST_WIDE;
        res_next.data = b_sum;
        skip_next = b_co;
      end
      NCAL_OP_ADDS_ACC_MEM: begin
        res_next.dst = NCAL_DST_ACC;
        res_next.data = {4'h0, n_sum};
        skip_next = n_co;
      end
      NCAL_OP_ADDS_WIDE_PAIR: begin
        res_next.dst = NCAL_DST_WIDE;
        res_next.data = b_sum;
        skip_next = b_co;
      end
      NCAL_OP_ADDS_PAIR_WIDE: begin
        b_a = op_i.pair;
        b_b = wide;
        res_next.dst = NCAL_DST_PAIR;
        res_next.data = b_sum;
        skip_next = b_co;
        bad_next = (op_i.sel == `NCAL_PAIR_WIDE);
      end
      NCAL_OP_ADD_CIN_ACC_MEM: begin
        n_cin = carry_flag_reg;
        res_next.dst = NCAL_DST_ACC;
        res_next.data = {4'h0, n_sum};
        carry_we = 1'b1;
        carry_next = n_co;
        conv_op = 1'b1;
        conv_skip_next = n_co;
      end
      NCAL_OP_ADD_CIN_WIDE_PAIR: begin
        b_cin = carry_flag_reg;
        res_next.dst = NCAL_DST_WIDE;
        res_next.data = b_sum;
        carry_we = 1'b1;
        carry_next = b_co;
      end
      NCAL_OP_ADD_CIN_PAIR_WIDE: begin
        b_a = op_i.pair;
        b_b = wide;
        b_cin = carry_flag_reg;
        res_next.dst = NCAL_DST_PAIR;
        res_next.data = b_sum;
        carry_we = 1'b1;
        carry_next = b_co;
        bad_next = (op_i.sel == `NCAL_PAIR_WIDE);
      end
      NCAL_OP_SUB_SKIP_ACC_MEM: begin
        n_sub = 1'b1;
        res_next.dst = NCAL_DST_ACC;
        res_next.data = {4'h0, n_sum};
        skip_next = n_co;
      end
      NCAL_OP_SUB_SKIP_WIDE_PAIR: begin
        b_sub = 1'b1;
        res_next.dst = NCAL_DST_WIDE;
        res_next.data = b_sum;
        skip_next = b_co;
      end
      NCAL_OP_SUB_SKIP_PAIR_WIDE: begin
        b_a = op_i.pair;
        b_b = wide;
        b_sub = 1'b1;
        res_next.dst = NCAL_DST_PAIR;
        res_next.data = b_sum;
        skip_next = b_co;
        bad_next = (op_i.sel == `NCAL_PAIR_WIDE);
      end
      NCAL_OP_SUB_BIN_ACC_MEM: begin
        n_sub = 1'b1;
        n_cin = carry_flag_reg;
        res_next.dst = NCAL_DST_ACC;
        res_next.data = {4'h0, n_sum};
        carry_we = 1'b1;
        carry_next = n_co;
        conv_op = 1'b1;
        conv_skip_next = !n_co;
      end
      NCAL_OP_SUB_BIN_WIDE_PAIR: begin
        b_sub = 1'b1;
        b_cin = carry_flag_reg;
        res_next.dst = NCAL_DST_WIDE;
        res_next.data = b_sum;
        carry_we = 1'b1;
        carry_next = b_co;
      end
      NCAL_OP_SUB_BIN_PAIR_WIDE: begin
        b_a = op_i.pair;
        b_b = wide;
        b_sub = 1'b1;
        b_cin = carry_flag_reg;
        res_next.dst = NCAL_DST_PAIR;
        res_next.data = b_sum;
        carry_we = 1'b1;
        carry_next = b_co;
        bad_next = (op_i.sel == `NCAL_PAIR_WIDE);
      end
      NCAL_OP_AND_ACC_IMM: begin
        res_next.dst = NCAL_DST_ACC;
        res_next.data = {4'h0, op_i.acc & op_i.imm[3:0]};
      end
      NCAL_OP_AND_ACC_MEM: begin
        res_next.dst = NCAL_DST_ACC;
        res_next.data = {4'h0, op_i.acc & op_i.mem};
      end
      NCAL_OP_AND_WIDE_PAIR: begin
        res_next.dst = NCAL_DST_WIDE;
        res_next.data = wide & op_i.pair;
      end
      NCAL_OP_AND_PAIR_WIDE: begin
        res_next.dst = NCAL_DST_PAIR;
        res_next.data = op_i.pair & wide;
        bad_next = (op_i.sel == `NCAL_PAIR_WIDE);
      end
      NCAL_OP_OR_ACC_IMM: begin
        res_next.dst = NCAL_DST_ACC;
        res_next.data = {4'h0, op_i.acc | op_i.imm[3:0]};
      end
      NCAL_OP_OR_ACC_MEM: begin
        res_next.dst = NCAL_DST_ACC;
        res_next.data = {4'h0, op_i.acc | op_i.mem};
      end
      NCAL_OP_OR_WIDE_PAIR: begin
        res_next.dst = NCAL_DST_WIDE;
        res_next.data = wide | op_i.pair;
      end
      NCAL_OP_OR_PAIR_WIDE: begin
        res_next.dst = NCAL_DST_PAIR;
        res_next.data = op_i.pair | wide;
        bad_next = (op_i.sel == `NCAL_PAIR_WIDE);
      end
      NCAL_OP_XOR_ACC_IMM: begin
        res_next.dst = NCAL_DST_ACC;
        res_next.data = {4'h0, op_i.acc ^ op_i.imm[3:0]};
      end
      NCAL_OP_XOR_ACC_MEM: begin
        res_next.dst = NCAL_DST_ACC;
        res_next.data = {4'h0, op_i.acc ^ op_i.mem};
      end
      NCAL_OP_XOR_WIDE_PAIR: begin
        res_next.dst = NCAL_DST_WIDE;
        res_next.data = wide ^ op_i.pair;
      end
      NCAL_OP_XOR_PAIR_WIDE: begin
        res_next.dst = NCAL_DST_PAIR;
        res_next.data = op_i.pair ^ wide;
        bad_next = (op_i.sel == `NCAL_PAIR_WIDE);
      end
      NCAL_OP_ROT: begin
        res_next.dst = NCAL_DST_ACC;
        res_next.data = {4'h0, carry_flag_reg, op_i.acc[3:1]};
        carry_we = 1'b1;
        carry_next = op_i.acc[0];
      end
      NCAL_OP_NOT: begin
        res_next.dst = NCAL_DST_ACC;
        res_next.data = {4'h0, ~op_i.acc};
      end
      NCAL_OP_INC_REG: begin
        n_a = op_i.reg_val;
        n_b = `NCAL_NIB_ONE;
        res_next.dst = NCAL_DST_REG;
        res_next.data = {4'h0, n_sum};
        skip_next = (n_sum == `NCAL_NIB_ZERO);
      end
      NCAL_OP_INC_PAIR: begin
        b_a = op_i.pair;
        b_b = `NCAL_BYTE_ONE;
        res_next.dst = NCAL_DST_PAIR;
        res_next.data = b_sum;
        skip_next = (b_sum == `NCAL_BYTE_ZERO);
        bad_next = (op_i.sel != `NCAL_PAIR_PTR) && (op_i.sel != `NCAL_PAIR_DE) &&
          (op_i.sel != `NCAL_PAIR_BC);
      end
      NCAL_OP_INC_MEM_PTR: begin
        n_a = op_i.mem;
        n_b = `NCAL_NIB_ONE;
        res_next.dst = NCAL_DST_MEM;
        res_next.data = {4'h0, n_sum};
        res_next.addr = op_i.pointer;
        skip_next = (n_sum == `NCAL_NIB_ZERO);
      end
      NCAL_OP_INC_MEM_DIR: begin
        n_a = op_i.mem;
        n_b = `NCAL_NIB_ONE;
        res_next.dst = NCAL_DST_MEM;
        res_next.data = {4'h0, n_sum};
        res_next.addr = op_i.imm;
        skip_next = (n_sum == `NCAL_NIB_ZERO);
      end
      default: begin
        bad_next = 1'b1;
      end
    endcase
    if (bad_next) begin
      res_next.dst = NCAL_DST_NONE;
      skip_next = 1'b0;
      carry_we = 1'b0;
    end
  end

  // carry flag
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      carry_flag_reg <= `NCAL_CARRY_RST;
    end else if (fire && carry_we) begin
      carry_flag_reg <= carry_next;
    end
  end

  // shadow of a skip: the next strobe is eaten
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      skip_shadow_reg <= 1'b0;
    end else if (op_valid_i) begin
      skip_shadow_reg <= fire && skip_next;
    end
  end

  // outcome of an accumulator-memory carry-in add or borrow-in subtract, seen by the next op only
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      conv_pending_reg <= 1'b0;
      conv_skip_reg <= 1'b0;
    end else if (op_valid_i) begin
      conv_pending_reg <= fire && conv_op && !bad_next;
      conv_skip_reg <= conv_skip_next;
    end
  end

  // registered answer, one cycle after the strobe
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      done_reg <= 1'b0;
      res_reg <= '0;
      skip_req_reg <= 1'b0;
      illegal_reg <= 1'b0;
    end else begin
      done_reg <= op_valid_i;
      skip_req_reg <= fire && skip_next;
      illegal_reg <= fire && bad_next;
      if (op_valid_i) begin
        res_reg <= res_next;
        if (discard) begin
          res_reg.dst <= NCAL_DST_NONE;
        end
      end
    end
  end

  assign done_o = done_reg;
  assign res_o = res_reg;
  assign skip_req_o = skip_req_reg;
  assign illegal_o = illegal_reg;
  assign carry_flag_o = carry_flag_reg;
endmodule // ncal_alu

/* File: ncal_map.svh */
`ifndef NCAL_MAP_SVH
`define NCAL_MAP_SVH

`define NCAL_NIB_W 4
`define NCAL_BYTE_W 8
`define NCAL_SEL_W 3
// register pair select codes, bank bit is the msb
`define NCAL_PAIR_WIDE 3'h0
`define NCAL_PAIR_PTR 3'h1
`define NCAL_PAIR_DE 3'h2
`define NCAL_PAIR_BC 3'h3
`define NCAL_CARRY_RST 1'b0
`define NCAL_NIB_ONE 4'h1
`define NCAL_BYTE_ONE 8'h01
`define NCAL_NIB_ZERO 4'h0
`define NCAL_BYTE_ZERO 8'h00
`endif

/* File: ncal_pkg.sv */
package ncal_pkg;
  typedef enum logic [5:0] {
    NCAL_OP_NOP,
    NCAL_OP_ADDS_ACC_IMM,
    NCAL_OP_ADDS_WIDE_IMM,
    NCAL_OP_ADDS_ACC_MEM,
    NCAL_OP_ADDS_WIDE_PAIR,
    NCAL_OP_ADDS_PAIR_WIDE,
    NCAL_OP_ADD_CIN_ACC_MEM,
    NCAL_OP_ADD_CIN_WIDE_PAIR,
    NCAL_OP_ADD_CIN_PAIR_WIDE,
    NCAL_OP_SUB_SKIP_ACC_MEM,
    NCAL_OP_SUB_SKIP_WIDE_PAIR,
    NCAL_OP_SUB_SKIP_PAIR_WIDE,
    NCAL_OP_SUB_BIN_ACC_MEM,
    NCAL_OP_SUB_BIN_WIDE_PAIR,
    NCAL_OP_SUB_BIN_PAIR_WIDE,
    NCAL_OP_AND_ACC_IMM,
    NCAL_OP_AND_ACC_MEM,
    NCAL_OP_AND_WIDE_PAIR,
    NCAL_OP_AND_PAIR_WIDE,
    NCAL_OP_OR_ACC_IMM,
    NCAL_OP_OR_ACC_MEM,
    NCAL_OP_OR_WIDE_PAIR,
    NCAL_OP_OR_PAIR_WIDE,
    NCAL_OP_XOR_ACC_IMM,
    NCAL_OP_XOR_ACC_MEM,
    NCAL_OP_XOR_WIDE_PAIR,
    NCAL_OP_XOR_PAIR_WIDE,
    NCAL_OP_ROT,
    NCAL_OP_NOT,
    NCAL_OP_INC_REG,
    NCAL_OP_INC_PAIR,
    NCAL_OP_INC_MEM_PTR,
    NCAL_OP_INC_MEM_DIR
  } ncal_op_type;

  typedef enum logic [2:0] {
    NCAL_DST_NONE,
    NCAL_DST_ACC,
    NCAL_DST_WIDE,
    NCAL_DST_PAIR,
    NCAL_DST_REG,
    NCAL_DST_MEM
  } ncal_dst_type;

  // one instruction with all the operands the sequencer fetched for it
  typedef struct packed {
    ncal_op_type code;
    logic [2:0] sel;
    logic [3:0] acc;
    logic [3:0] high;
    logic [7:0] pair;
    logic [3:0] reg_val;
    logic [3:0] mem;
    logic [7:0] imm;
    logic [7:0] pointer;
  } ncal_req_type;

  typedef struct packed {
    ncal_dst_type dst;
    logic [2:0] sel;
    logic [7:0] data;
    logic [7:0] addr;
  } ncal_res_type;
endpackage

/* File: ncal_addsub.sv */
`timescale 1ns/1ps
module ncal_addsub #(
  parameter int W = 4
) (
  input wire logic [W-1:0] a_i, // minuend or augend
  input wire logic [W-1:0] b_i, // subtrahend or addend
  input wire logic cin_i, // carry or borrow in
  input wire logic sub_i, // high to subtract
  output logic [W-1:0] sum_o, // result
  output logic cout_o // carry out, or borrow when subtracting
);
  logic [W:0] full;

  always_comb begin
    if (sub_i) begin
      full = {1'b0, a_i} - {1'b0, b_i} - {{W{1'b0}}, cin_i};
    end else begin
      full = {1'b0, a_i} + {1'b0, b_i} + {{W{1'b0}}, cin_i};
    end
  end

  assign sum_o = full[W-1:0];
  assign cout_o = full[W];
endmodule // ncal_addsub

/* File: ncal_alu_properties.sv */
`timescale 1ns/1ps
module ncal_alu_properties (
  input wire logic core_clk_i, // core clock
  input wire logic resetn_i, // synchronous reset, active low
  input wire logic op_valid_i, // instruction strobe
  input wire ncal_pkg::ncal_req_type op_i, // instruction and operands
  input wire logic done_o, // result strobe
  input wire ncal_pkg::ncal_res_type res_o, // write-back target and data
  input wire logic skip_req_o, // skip request
  input wire logic illegal_o, // bad destination
  input wire logic carry_flag_o // carry flag
);
  import ncal_pkg::*;
  logic shadow_reg;
  logic live;
  logic keeps_carry;
  logic no_skip;
  logic [4:0] add_with_carry_in_sum;
  default clocking def_cb @(posedge core_clk_i);
  endclocking
  default disable iff (!resetn_i);
  // the skip shadow survives idle cycles until the next strobe eats it
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i || op_valid_i) begin
      shadow_reg <= 1'b0;
    end else if (skip_req_o) begin
      shadow_reg <= 1'b1;
    end
  end
  assign live = op_valid_i && !skip_req_o && !shadow_reg;
  assign keeps_carry = !(op_i.code inside {
    [NCAL_OP_ADD_CIN_ACC_MEM:NCAL_OP_ADD_CIN_PAIR_WIDE],
    [NCAL_OP_SUB_BIN_ACC_MEM:NCAL_OP_SUB_BIN_PAIR_WIDE], NCAL_OP_ROT});
  assign no_skip = op_i.code inside {
    [NCAL_OP_ADD_CIN_ACC_MEM:NCAL_OP_ADD_CIN_PAIR_WIDE],
    [NCAL_OP_SUB_BIN_ACC_MEM:NCAL_OP_NOT]};
  assign add_with_carry_in_sum = {1'b0, op_i.acc} + {1'b0, op_i.mem} + {4'h0, carry_flag_o};
  AST_SHADOW_DROP: assert property (
    op_valid_i && !live |=> done_o && res_o.dst == NCAL_DST_NONE && !skip_req_o)
    else $error("discarded instruction had an effect");
  AST_CARRY_HELD: assert property (op_valid_i && keeps_carry |=> $stable(carry_flag_o))
    else $error("carry changed by an instruction that keeps it");
  AST_NO_SKIP: assert property (op_valid_i && no_skip |=> !skip_req_o)
    else $error("skip raised by a non-skip form");
  AST_ROT: assert property (live && op_i.code == NCAL_OP_ROT |=>
    carry_flag_o == $past(op_i.acc[0]) &&
    res_o.data[3:0] == {$past(carry_flag_o), $past(op_i.acc[3:1])}) else $error("bad rotate");
  AST_NOT: assert property (live && op_i.code == NCAL_OP_NOT |=>
    res_o.dst == NCAL_DST_ACC && res_o.data[3:0] == ~$past(op_i.acc)) else $error("bad invert");
  AST_INC_REG: assert property (live && op_i.code == NCAL_OP_INC_REG |=>
    skip_req_o == ($past(op_i.reg_val) == 4'hF)) else $error("bad register increment skip");
  AST_INC_PAIR: assert property (live && op_i.code == NCAL_OP_INC_PAIR && op_i.sel == 3'h1 |=>
    res_o.data == $past(op_i.pair) + 8'h01 && skip_req_o == ($past(op_i.pair) == 8'hFF))
    else $error("bad pair increment");
  AST_ADD_CIN_CARRY: assert property (live && op_i.code == NCAL_OP_ADD_CIN_ACC_MEM |=>
    carry_flag_o == $past(add_with_carry_in_sum[4])) else $error("bad nibble add carry");
  AST_INC_DIR: assert property (live && op_i.code == NCAL_OP_INC_MEM_DIR |=>
    res_o.dst == NCAL_DST_MEM && res_o.addr == $past(op_i.imm)) else $error("bad direct address");
  AST_BAD_DST: assert property (
    live && op_i.code == NCAL_OP_AND_PAIR_WIDE && op_i.sel == 3'h0 |=>
    illegal_o && res_o.dst == NCAL_DST_NONE) else $error("wide pair taken as destination");
  cover property (op_valid_i && shadow_reg);
  cover property (op_valid_i && skip_req_o);
  cover property (illegal_o);
endmodule // ncal_alu_properties
bind ncal_alu ncal_alu_properties u_props (.core_clk_i, .resetn_i, .op_valid_i, .op_i,
  .done_o, .res_o, .skip_req_o, .illegal_o, .carry_flag_o);

/* File: ncal_mem_model.sv */
`timescale 1ns/1ps
module ncal_mem_model (
  input wire logic core_clk_i, // core clock
  input wire logic [7:0] rd_addr_i, // nibble address
  input wire logic done_i, // result strobe
  input wire ncal_pkg::ncal_res_type res_i, // write-back from the unit
  output logic [3:0] rd_data_o // nibble at rd_addr_i
);
  import ncal_pkg::*;
  logic [3:0] mem_reg [256];
  // each nibble starts as the low half of its own address
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem_reg[i] = i[3:0];
    end
  end
  assign rd_data_o = mem_reg[rd_addr_i];
  // only a memory target writes; discarded answers name none
  always @(posedge core_clk_i) begin
    if (done_i && res_i.dst == NCAL_DST_MEM) begin
      mem_reg[res_i.addr] <= res_i.data[3:0];
    end
  end
endmodule // ncal_mem_model

/* File: ncal_alu_tb.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin \
  $display("MISMATCH %s expected %h seen %h", n, e, g); n_mismatch++; end end
module ncal_alu_tb;
  import ncal_pkg::*;
  typedef struct packed {
    ncal_req_type req;
    ncal_dst_type dst;
    logic [7:0] data;
    logic [1:0] sc;
  } ncal_row_type;
  logic core_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic op_valid_i = 1'b0;
  ncal_req_type op_i = '0;
  logic done_o;
  ncal_res_type res_o;
  logic skip_req_o;
  logic illegal_o;
  logic carry_flag_o;
  logic [7:0] rd_addr = 8'h00;
  logic [3:0] rd_data;
  int n_mismatch = 0;
  int checked = 0;
  int cycles = 0;
  ncal_row_type rows[$];
  ncal_row_type conv[$];
  ncal_row_type disc;
  ncal_row_type x;
  ncal_alu dut (.core_clk_i, .resetn_i, .op_valid_i, .op_i, .done_o, .res_o, .skip_req_o,
    .illegal_o, .carry_flag_o);
  ncal_mem_model mem (.core_clk_i, .rd_addr_i(rd_addr), .done_i(done_o), .res_i(res_o),
    .rd_data_o(rd_data));
  initial begin
    forever #50 core_clk_i = ~core_clk_i;
  end
  // sc: bit 1 expected skip, bit 0 expected carry after the answer
  function automatic ncal_row_type m(input ncal_op_type c, input logic [7:0] wa, ob,
    input ncal_dst_type d, input logic [7:0] data, input int sc);
    ncal_row_type r;
    r.req = '{c, 3'h1, wa[3:0], wa[7:4], ob, ob[3:0], 4'h0, ob, ob};
    r.dst = d;
    r.data = data;
    r.sc = sc[1:0];
    return r;
  endfunction
  task automatic chk(input ncal_row_type r);
    #1;
    `CHK("done", 1'b1, done_o)
    `CHK("dst", r.dst, res_o.dst)
    if (r.dst != NCAL_DST_NONE) `CHK("data", r.data, res_o.data)
    `CHK("skip", r.sc[1], skip_req_o)
    `CHK("carry", r.sc[0], carry_flag_o)
  endtask
  // the memory nibble is fetched at the pointer (at the immediate for a direct increment) a cycle ahead of the strobe
  task automatic strobe(input ncal_row_type r);
    @(posedge core_clk_i);
    rd_addr <= (r.req.code == NCAL_OP_INC_MEM_DIR) ? r.req.imm : r.req.pointer;
    @(posedge core_clk_i);
    r.req.mem = rd_data;
    op_valid_i <= 1'b1;
    op_i <= r.req;
  endtask
  task automatic send(input ncal_row_type r);
    strobe(r);
    @(posedge core_clk_i);
    op_valid_i <= 1'b0;
    chk(r);
  endtask
  task automatic send2(input ncal_row_type a, b);
    strobe(a);
    @(posedge core_clk_i);
    op_i <= b.req;
    chk(a);
    @(posedge core_clk_i);
    op_valid_i <= 1'b0;
    chk(b);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 1000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial begin
    disc = m(NCAL_OP_AND_ACC_IMM, 8'h0F, 8'h0F, NCAL_DST_NONE, 8'h00, 0);
    rows = '{m(NCAL_OP_ADDS_WIDE_IMM,8'hFF,8'h01,NCAL_DST_WIDE,8'h00,2),
      m(NCAL_OP_ADD_CIN_WIDE_PAIR,8'hF0,8'h20,NCAL_DST_WIDE,8'h10,1),
      m(NCAL_OP_ADD_CIN_PAIR_WIDE,8'h01,8'hFE,NCAL_DST_PAIR,8'h00,1),
      m(NCAL_OP_SUB_BIN_WIDE_PAIR,8'h10,8'h0F,NCAL_DST_WIDE,8'h00,0),
      m(NCAL_OP_SUB_BIN_PAIR_WIDE,8'h01,8'h00,NCAL_DST_PAIR,8'hFF,1),
      m(NCAL_OP_ADDS_ACC_MEM,8'h0A,8'h07,NCAL_DST_ACC,8'h01,3),
      m(NCAL_OP_ADDS_WIDE_PAIR,8'h80,8'h80,NCAL_DST_WIDE,8'h00,3),
      m(NCAL_OP_ADDS_PAIR_WIDE,8'h01,8'h41,NCAL_DST_PAIR,8'h42,1),
      m(NCAL_OP_ROT,8'h04,8'h00,NCAL_DST_ACC,8'h0A,0),
      m(NCAL_OP_ADD_CIN_ACC_MEM,8'h08,8'h07,NCAL_DST_ACC,8'h0F,0),
      m(NCAL_OP_ADD_CIN_ACC_MEM,8'h0F,8'h01,NCAL_DST_ACC,8'h00,1),
      m(NCAL_OP_SUB_SKIP_ACC_MEM,8'h03,8'h05,NCAL_DST_ACC,8'h0E,3),
      m(NCAL_OP_SUB_SKIP_WIDE_PAIR,8'h50,8'h30,NCAL_DST_WIDE,8'h20,1),
      m(NCAL_OP_SUB_SKIP_PAIR_WIDE,8'h31,8'h30,NCAL_DST_PAIR,8'hFF,3),
      m(NCAL_OP_SUB_BIN_ACC_MEM,8'h05,8'h04,NCAL_DST_ACC,8'h00,0),
      m(NCAL_OP_SUB_BIN_ACC_MEM,8'h01,8'h02,NCAL_DST_ACC,8'h0F,1),
      m(NCAL_OP_AND_ACC_IMM,8'h0C,8'h0A,NCAL_DST_ACC,8'h08,1),
      m(NCAL_OP_AND_ACC_MEM,8'h0F,8'h06,NCAL_DST_ACC,8'h06,1),
      m(NCAL_OP_AND_WIDE_PAIR,8'hF0,8'h3C,NCAL_DST_WIDE,8'h30,1),
      m(NCAL_OP_AND_PAIR_WIDE,8'h0F,8'h3C,NCAL_DST_PAIR,8'h0C,1),
      m(NCAL_OP_OR_ACC_IMM,8'h0C,8'h03,NCAL_DST_ACC,8'h0F,1),
      m(NCAL_OP_OR_ACC_MEM,8'h08,8'h01,NCAL_DST_ACC,8'h09,1),
      m(NCAL_OP_OR_WIDE_PAIR,8'hF0,8'h0F,NCAL_DST_WIDE,8'hFF,1),
      m(NCAL_OP_OR_PAIR_WIDE,8'h01,8'h80,NCAL_DST_PAIR,8'h81,1),
      m(NCAL_OP_XOR_ACC_IMM,8'h0F,8'h08,NCAL_DST_ACC,8'h07,1),
      m(NCAL_OP_XOR_ACC_MEM,8'h0F,8'h05,NCAL_DST_ACC,8'h0A,1),
      m(NCAL_OP_XOR_WIDE_PAIR,8'hFF,8'h0F,NCAL_DST_WIDE,8'hF0,1),
      m(NCAL_OP_XOR_PAIR_WIDE,8'h0F,8'hFF,NCAL_DST_PAIR,8'hF0,1),
      m(NCAL_OP_NOT,8'h05,8'h00,NCAL_DST_ACC,8'h0A,1),
      m(NCAL_OP_INC_REG,8'h00,8'h0F,NCAL_DST_REG,8'h00,3),
      m(NCAL_OP_INC_PAIR,8'h00,8'hFF,NCAL_DST_PAIR,8'h00,3),
      m(NCAL_OP_INC_MEM_PTR,8'h00,8'h0F,NCAL_DST_MEM,8'h00,3),
      m(NCAL_OP_INC_MEM_DIR,8'h00,8'hA3,NCAL_DST_MEM,8'h04,1),
      m(NCAL_OP_ADDS_ACC_MEM,8'h01,8'h0F,NCAL_DST_ACC,8'h01,1),
      m(NCAL_OP_ADDS_ACC_MEM,8'h01,8'hA3,NCAL_DST_ACC,8'h05,1)};
    conv = '{m(NCAL_OP_ADDS_ACC_IMM,8'h0F,8'h01,NCAL_DST_ACC,8'h00,3),
      m(NCAL_OP_AND_ACC_IMM,8'h0F,8'h0F,NCAL_DST_NONE,8'h00,1),
      m(NCAL_OP_ADD_CIN_ACC_MEM,8'h0E,8'h01,NCAL_DST_ACC,8'h00,1),
      m(NCAL_OP_ADDS_ACC_IMM,8'h03,8'h06,NCAL_DST_NONE,8'h00,1),
      m(NCAL_OP_ADD_CIN_ACC_MEM,8'h02,8'h01,NCAL_DST_ACC,8'h04,0),
      m(NCAL_OP_ADDS_ACC_IMM,8'h0F,8'h01,NCAL_DST_ACC,8'h00,0),
      m(NCAL_OP_SUB_BIN_ACC_MEM,8'h05,8'h01,NCAL_DST_ACC,8'h04,0),
      m(NCAL_OP_ADDS_ACC_IMM,8'h03,8'h06,NCAL_DST_NONE,8'h00,0),
      m(NCAL_OP_SUB_BIN_ACC_MEM,8'h00,8'h01,NCAL_DST_ACC,8'h0F,1),
      m(NCAL_OP_ADDS_ACC_IMM,8'h0F,8'h01,NCAL_DST_ACC,8'h00,1)};
    repeat (6) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    #1;
    `CHK("reset carry", 1'b0, carry_flag_o)
    foreach (rows[i]) begin
      send(rows[i]);
      if (rows[i].sc[1]) begin
        disc.sc[0] = rows[i].sc[0];
        send(disc);
      end
    end
    for (int i = 0; i < 10; i += 2) begin
      send2(conv[i], conv[i + 1]);
    end
    x = m(NCAL_OP_AND_PAIR_WIDE, 8'h0F, 8'h3C, NCAL_DST_NONE, 8'h00, 1);
    x.req.sel = 3'h0;
    send(x);
    `CHK("illegal", 1'b1, illegal_o)
    // direct increment must write at the immediate address, not the pointer
    x = m(NCAL_OP_INC_MEM_DIR, 8'h00, 8'h51, NCAL_DST_MEM, 8'h02, 1);
    x.req.pointer = 8'h00;
    send(x);
    `CHK("addr", 8'h51, res_o.addr)
    x = m(NCAL_OP_INC_REG, 8'h00, 8'h03, NCAL_DST_REG, 8'h04, 1);
    x.req.sel = 3'h6;
    send(x);
    `CHK("sel", 3'h6, res_o.sel)
    // a reset in mid-run must drop the pending skip shadow
    send(conv[0]);
    @(posedge core_clk_i);
    resetn_i <= 1'b0;
    @(posedge core_clk_i);
    resetn_i <= 1'b1;
    #1;
    `CHK("mid reset carry", 1'b0, carry_flag_o)
    send(m(NCAL_OP_AND_ACC_IMM, 8'h0F, 8'h05, NCAL_DST_ACC, 8'h05, 0));
    give_verdict();
  end
endmodule // ncal_alu_tb
